// ---- rtl/dcs_pkg.sv ----
// Constants, register map and encodings of the dual source command select.
// Assumes a 32-bit AHB-Lite register bus and a 250 MHz control clock.
package dcs_pkg;
   // Terminal counts
   localparam int          NUM_TERM      = 5;
   localparam int          STD_TERM      = 3;
   // Register byte offsets
   localparam logic [7:0]  OFS_CMD1      = 8'h00;
   localparam logic [7:0]  OFS_FRQ1      = 8'h04;
   localparam logic [7:0]  OFS_CMD2      = 8'h08;
   localparam logic [7:0]  OFS_FRQ2      = 8'h0C;
   localparam logic [7:0]  OFS_FUNC0     = 8'h10;
   localparam logic [7:0]  OFS_STRIDE    = 8'h04;
   localparam logic [7:0]  OFS_VIN       = 8'h24;
   localparam logic [7:0]  OFS_STAT      = 8'h28;
   localparam logic [7:0]  OFS_LVT       = 8'h2C;
   // Values after reset
   localparam logic [7:0]  RST_CMD1      = 8'h01;
   localparam logic [7:0]  RST_FRQ1      = 8'h00;
   localparam logic [7:0]  RST_CMD2      = 8'h01;
   localparam logic [7:0]  RST_FRQ2      = 8'h00;
   localparam logic [NUM_TERM-1:0][7:0] RST_FUNC = {8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0]  RST_VIN       = 8'hDC;
   // Setting limits and codes
   localparam logic [7:0]  FUNC_ALT_SRC  = 8'h16;
   localparam logic [7:0]  FUNC_MAX      = 8'h1B;
   localparam logic [7:0]  CMD_MAX       = 8'h03;
   localparam logic [7:0]  FRQ_MAX       = 8'h0A;
   localparam logic [7:0]  VIN_MIN       = 8'hAA;
   localparam logic [7:0]  VIN_MAX       = 8'hF0;
   // Command source codes
   localparam logic [1:0]  CMD_KEYPAD    = 2'h0;
   localparam logic [1:0]  CMD_TERM_FR   = 2'h1;
   localparam logic [1:0]  CMD_TERM_RD   = 2'h2;
   localparam logic [1:0]  CMD_SERIAL    = 2'h3;
   // Frequency source codes
   localparam logic [3:0]  FRQ_KEY1      = 4'h0;
   localparam logic [3:0]  FRQ_KEY2      = 4'h1;
   localparam logic [3:0]  FRQ_POT       = 4'h2;
   localparam logic [3:0]  FRQ_VOLT      = 4'h3;
   localparam logic [3:0]  FRQ_CUR       = 4'h4;
   localparam logic [3:0]  FRQ_CUR_V     = 4'h5;
   localparam logic [3:0]  FRQ_POT_CUR   = 4'h6;
   localparam logic [3:0]  FRQ_POT_CURV  = 4'h7;
   localparam logic [3:0]  FRQ_POT_VOLT  = 4'h8;
   localparam logic [3:0]  FRQ_SERIAL    = 4'h9;
   localparam logic [3:0]  FRQ_UPDOWN    = 4'hA;
   localparam int          NUM_FRQ       = 11;
   // Status register fields
   localparam int          ST_ALT        = 0;
   localparam int          ST_RUN        = 1;
   localparam int          ST_REV        = 2;
   localparam int          ST_CMD        = 4;
   localparam int          ST_FRQ        = 8;
   localparam int          ST_KEY        = 12;
   // Low-voltage trip level as a fraction of the nominal voltage, in 1/256
   localparam logic [7:0]  LV_RATIO      = 8'hC0;
   // Debounce time of the terminal inputs
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          DB_TIME_NS    = 1000000;
   localparam int          DB_CYCLES     = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- rtl/dcs_term_if.sv ----
// Debounced multi-function terminal levels passed inside the block.
// Assumes both ends run on the same control clock.
`timescale 1ns/1ps
interface dcs_term_if #(parameter int NT = 5);
   logic [NT-1:0] level;
   modport src (output level);
   modport dst (input  level);
endinterface

// ---- rtl/dcs_debounce.sv ----
// Synchroniser and debounce filter for the multi-function terminals.
// Assumes raw contact levels that may bounce; one filter per terminal.
`timescale 1ns/1ps
module dcs_debounce
   import dcs_pkg::*;
#(
   parameter int NT        = dcs_pkg::NUM_TERM,
   parameter int DB_CYCLES = dcs_pkg::DB_CYCLES
)(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic [NT-1:0] raw_in,
   dcs_term_if.src            tif
);
   localparam int            CW      = $clog2(DB_CYCLES + 1);
   localparam logic [CW-1:0] DB_LAST = CW'(DB_CYCLES - 1);

   typedef struct packed {
      logic [NT-1:0]         s1;
      logic [NT-1:0]         s2;
      logic [NT-1:0]         stb;
      logic [NT-1:0][CW-1:0] cnt;
   } dcs_db_t;

   dcs_db_t               st_r;
   dcs_db_t               st_nxt;
   logic [NT-1:0]         stb_nxt;
   logic [NT-1:0][CW-1:0] cnt_nxt;

   // Per terminal: a new level is taken only after it held for the whole time
   genvar i;
   generate
      for (i = 0; i < NT; i++)
      begin : g_term
         assign stb_nxt[i] = (st_r.s2[i] != st_r.stb[i] && st_r.cnt[i] == DB_LAST) ?
                             st_r.s2[i] : st_r.stb[i];
         assign cnt_nxt[i] = (st_r.s2[i] == st_r.stb[i] || st_r.cnt[i] == DB_LAST) ?
                             '0 : st_r.cnt[i] + 1'b1;
      end
   endgenerate

   // First stage feeds only the second stage
   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.s1  = raw_in;
      st_nxt.s2  = st_r.s1;
      st_nxt.stb = stb_nxt;
      st_nxt.cnt = cnt_nxt;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tif.level = st_r.stb;

   // A filtered level only moves after a full debounce count
   db_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(st_r.stb) |-> st_r.stb == $past(st_r.s2) && $past(st_r.cnt) != '0)
      else $error("debounced level moved without count");
endmodule

// ---- rtl/dcs_top.sv ----
// Dual source command select: chooses run command and frequency source.
// Assumes an AHB-Lite master, synchronous terminal and key inputs.
// Summary of operation
// - Command and frequency selection switch together
// - Select inactive or unassigned: first set used
// - Select active: second set used
// - Terminal selects only when function code 22
// - Fourth and fifth terminals only advanced variant
// - Code 0: keypad run and stop keys
// - Code 1: forward and reverse terminals run
// - Code 2: forward runs, reverse picks direction
// - Command codes 0 to 3, 3 serial
// - Frequency codes 0,1: keypad sources 1,2
// - Codes 2 to 8: analog and combinations
// - Code 9 serial, code 10 up-down
// - Current, current combination, serial options advanced only
// - Switching: run follows new forward terminal
// - Switching to stopped source decelerates
// - Voltage 170 to 240 sets trip level
`timescale 1ns/1ps
module dcs_top
   import dcs_pkg::*;
#(
   parameter bit ADV_IO    = 1'b1,
   parameter int DB_CYCLES = dcs_pkg::DB_CYCLES
)(
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output      logic                          hreadyout,
   output      logic                          hresp,
   output      logic [31:0]                   hrdata,
   input  wire logic [dcs_pkg::NUM_TERM-1:0]  term_in,
   input  wire logic                          fwd_terminal,
   input  wire logic                          rev_terminal,
   input  wire logic                          key_run,
   input  wire logic                          key_stop,
   input  wire logic                          serial_run,
   input  wire logic                          serial_reverse,
   output      logic                          alt_source_active,
   output      logic                          run_cmd,
   output      logic                          reverse_cmd,
   output      logic [1:0]                    cmd_source,
   output      logic [3:0]                    freq_source,
   output      logic [dcs_pkg::NUM_FRQ-1:0]   freq_source_en,
   output      logic [7:0]                    lv_trip_level
);
   localparam int NT = NUM_TERM;

   typedef struct packed {
      logic [7:0]          cmd1;
      logic [7:0]          frq1;
      logic [7:0]          cmd2;
      logic [7:0]          frq2;
      logic [NT-1:0][7:0]  func;
      logic [7:0]          vin;
      logic [7:0]          lvt;
      logic                alt;
      logic [1:0]          act_cmd;
      logic [3:0]          act_frq;
      logic [NUM_FRQ-1:0]  frq_en;
      logic                key_run;
      logic                run;
      logic                rev;
      logic                dph_wr;
      logic [7:0]          dph_addr;
      logic [31:0]         rdata;
   } dcs_state_t;

   localparam dcs_state_t ST_RESET = '{
      cmd1: RST_CMD1, frq1: RST_FRQ1, cmd2: RST_CMD2, frq2: RST_FRQ2,
      func: RST_FUNC, vin: RST_VIN, lvt: 8'hA5, alt: 1'b0,
      act_cmd: RST_CMD1[1:0], act_frq: RST_FRQ1[3:0],
      frq_en: NUM_FRQ'(1) << RST_FRQ1[3:0], key_run: 1'b0, run: 1'b0,
      rev: 1'b0, dph_wr: 1'b0, dph_addr: 8'h00, rdata: 32'h0000_0000};

   dcs_state_t    st_r;
   dcs_state_t    st_nxt;
   logic [NT-1:0] alt_match;
   logic          acc;
   logic [15:0]   prod;

   dcs_term_if #(.NT(NT)) tif ();

   // Filters all multi-function terminals so the select has one clean edge
   dcs_debounce #(
      .NT        (NT),
      .DB_CYCLES (DB_CYCLES)
   ) u_debounce (
      .hclk    (hclk),
      .hresetn (hresetn),
      .raw_in  (term_in),
      .tif     (tif)
   );

   // Terminal present in this variant
   function automatic logic term_avail(input int idx);
      return ADV_IO || idx < STD_TERM;
   endfunction

   // Command code legal in this variant
   function automatic logic cmd_legal(input logic [7:0] v);
      return v <= CMD_MAX && (ADV_IO || v[1:0] != CMD_SERIAL);
   endfunction

   // Frequency code legal in this variant
   function automatic logic frq_legal(input logic [7:0] v);
      logic adv_only;
      adv_only = v[3:0] == FRQ_CUR || v[3:0] == FRQ_CUR_V || v[3:0] == FRQ_POT_CUR
              || v[3:0] == FRQ_POT_CURV || v[3:0] == FRQ_SERIAL;
      return v <= FRQ_MAX && (ADV_IO || !adv_only);
   endfunction

   // Read multiplexer; unmapped offsets read zero
   function automatic logic [31:0] rd_mux(input dcs_state_t s, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         OFS_CMD1: v[7:0] = s.cmd1;
         OFS_FRQ1: v[7:0] = s.frq1;
         OFS_CMD2: v[7:0] = s.cmd2;
         OFS_FRQ2: v[7:0] = s.frq2;
         OFS_VIN:  v[7:0] = s.vin;
         OFS_LVT:  v[7:0] = s.lvt;
         OFS_STAT:
         begin
            v[ST_ALT]         = s.alt;
            v[ST_RUN]         = s.run;
            v[ST_REV]         = s.rev;
            v[ST_CMD +: 2]    = s.act_cmd;
            v[ST_FRQ +: 4]    = s.act_frq;
            v[ST_KEY]         = s.key_run;
         end
         default:
         begin
            for (int i = 0; i < NT; i++)
               if (a == OFS_FUNC0 + 8'(i * OFS_STRIDE) && term_avail(i))
                  v[7:0] = s.func[i];
         end
      endcase
      return v;
   endfunction

   // Terminals that currently carry the second-source function
   always_comb
   begin
      for (int i = 0; i < NT; i++)
         alt_match[i] = term_avail(i) && st_nxt.func[i] == FUNC_ALT_SRC;
   end

   // Whole next state: bus writes, source selection, command decode, bus reads
   always_comb
   begin
      st_nxt = st_r;
      acc    = hsel && htrans[1] && hready;
      // Data phase write; out-of-range settings are dropped, old value kept
      if (st_r.dph_wr)
      begin
         case (st_r.dph_addr)
            OFS_CMD1: if (cmd_legal(hwdata[7:0])) st_nxt.cmd1 = hwdata[7:0];
            OFS_FRQ1: if (frq_legal(hwdata[7:0])) st_nxt.frq1 = hwdata[7:0];
            OFS_CMD2: if (cmd_legal(hwdata[7:0])) st_nxt.cmd2 = hwdata[7:0];
            OFS_FRQ2: if (frq_legal(hwdata[7:0])) st_nxt.frq2 = hwdata[7:0];
            OFS_VIN:
               if (hwdata[7:0] >= VIN_MIN && hwdata[7:0] <= VIN_MAX)
                  st_nxt.vin = hwdata[7:0];
            default:
            begin
               for (int i = 0; i < NT; i++)
                  if (st_r.dph_addr == OFS_FUNC0 + 8'(i * OFS_STRIDE) && term_avail(i)
                      && hwdata[7:0] <= FUNC_MAX)
                     st_nxt.func[i] = hwdata[7:0];
            end
         endcase
      end
      // Both selections come from one set in one update, so they never split
      st_nxt.alt     = |(tif.level & alt_match);
      st_nxt.act_cmd = st_nxt.alt ? st_nxt.cmd2[1:0] : st_nxt.cmd1[1:0];
      st_nxt.act_frq = st_nxt.alt ? st_nxt.frq2[3:0] : st_nxt.frq1[3:0];
      st_nxt.frq_en  = NUM_FRQ'(1) << st_nxt.act_frq;
      // Keypad latch is dropped on a source change so no stale run carries over
      if (st_nxt.act_cmd != st_r.act_cmd)
         st_nxt.key_run = 1'b0;
      else if (key_stop)
         st_nxt.key_run = 1'b0;
      else if (key_run)
         st_nxt.key_run = 1'b1;
      // Run follows the present command of the active source only
      case (st_nxt.act_cmd)
         CMD_KEYPAD:
         begin
            st_nxt.run = st_nxt.key_run;
            st_nxt.rev = 1'b0;
         end
         CMD_TERM_FR:
         begin
            st_nxt.run = fwd_terminal ^ rev_terminal;
            st_nxt.rev = rev_terminal & ~fwd_terminal;
         end
         CMD_TERM_RD:
         begin
            st_nxt.run = fwd_terminal;
            st_nxt.rev = rev_terminal;
         end
         default:
         begin
            st_nxt.run = serial_run;
            st_nxt.rev = serial_reverse;
         end
      endcase
      // Trip level tracks the nominal voltage setting
      prod       = 16'(st_nxt.vin) * 16'(LV_RATIO);
      st_nxt.lvt = prod[15:8];
      // Address phase; read data are formed from the next state so that a
      // read right after a write already sees the written value
      st_nxt.dph_wr   = acc && hwrite;
      st_nxt.dph_addr = haddr[7:0];
      if (acc && !hwrite)
         st_nxt.rdata = rd_mux(st_nxt, haddr[7:0]);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_r <= ST_RESET;
      else
         st_r <= st_nxt;
   end

   // Zero wait states, always OKAY
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign hrdata            = st_r.rdata;
   assign alt_source_active = st_r.alt;
   assign run_cmd           = st_r.run;
   assign reverse_cmd       = st_r.rev;
   assign cmd_source        = st_r.act_cmd;
   assign freq_source       = st_r.act_frq;
   assign freq_source_en    = st_r.frq_en;
   assign lv_trip_level     = st_r.lvt;

   set_switch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(st_r.alt) && $stable(st_r.cmd1) && $stable(st_r.cmd2) && $stable(st_r.frq1)
      && $stable(st_r.frq2) && st_r.cmd1 != st_r.cmd2 && st_r.frq1 != st_r.frq2
      |-> $changed(st_r.act_cmd) && $changed(st_r.act_frq))
      else $error("selections did not switch together");
   first_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !st_r.alt |-> st_r.act_cmd == st_r.cmd1[1:0] && freq_source == st_r.frq1[3:0])
      else $error("first set not in use");
   second_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.alt |-> cmd_source == st_r.cmd2[1:0] && freq_source == st_r.frq2[3:0])
      else $error("second set not in use");
   alt_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_r.alt) |-> $past(|(tif.level & alt_match)))
      else $error("select rose without assigned terminal");
   std_term_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !ADV_IO |-> !alt_match[NT-1] && st_r.act_cmd != CMD_SERIAL
      && !st_r.frq_en[FRQ_SERIAL] && !st_r.frq_en[FRQ_CUR])
      else $error("advanced option in standard variant");
   keypad_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_source == CMD_KEYPAD && key_run && !key_stop) ##1 (cmd_source == CMD_KEYPAD)
      |-> st_r.key_run ##1 (cmd_source != CMD_KEYPAD || run_cmd))
      else $error("keypad run key not obeyed");
   term_fr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_source == CMD_TERM_FR && !fwd_terminal && rev_terminal)
      ##1 (cmd_source == CMD_TERM_FR) |-> run_cmd && reverse_cmd)
      else $error("reverse terminal not obeyed");
   term_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_source == CMD_TERM_RD) ##1 (cmd_source == CMD_TERM_RD)
      |-> run_cmd == $past(fwd_terminal) && reverse_cmd == $past(rev_terminal))
      else $error("run and direction terminals not obeyed");
   serial_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_source == CMD_SERIAL) ##1 (cmd_source == CMD_SERIAL)
      |-> run_cmd == $past(serial_run))
      else $error("serial run not obeyed");
   frq_onehot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $onehot(freq_source_en) && freq_source <= FRQ_MAX[3:0])
      else $error("frequency source enable not one-hot");
   stop_switch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(cmd_source) |-> !st_r.key_run)
      else $error("keypad run carried across switch");
   vin_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.vin >= VIN_MIN && st_r.vin <= VIN_MAX && lv_trip_level < st_r.vin)
      else $error("voltage setting out of range");
endmodule

// ---- test/dcs_contact_model.sv ----
// Model of the external terminal contacts that feed the select block.
// Assumes the bench sets the wanted contact levels just after a rising edge.
`timescale 1ns/1ps
module dcs_contact_model
   import dcs_pkg::*;
#(
   parameter int BOUNCE = 3
)(
   input  wire logic                hclk,
   input  wire logic [NUM_TERM-1:0] want,
   output      logic [NUM_TERM-1:0] term_in
);
   logic [NUM_TERM-1:0] prev;
   logic [NUM_TERM-1:0] mask;
   int                  cnt;

   initial
   begin
      term_in = '0;
      prev    = '0;
      mask    = '0;
      cnt     = 0;
   end

   // Real contacts chatter after every change; each bounce lasts one cycle,
   // shorter than the filter time, so only a settled level may pass
   always @(posedge hclk)
   begin
      if (want !== prev)
      begin
         mask    <= want ^ prev;
         prev    <= want;
         cnt     <= BOUNCE;
         term_in <= term_in ^ (want ^ prev);
      end
      else if (cnt > 0)
      begin
         cnt     <= cnt - 1;
         term_in <= (cnt == 1) ? want : (term_in ^ mask);
      end
   end
endmodule

// ---- test/test_dual_source_command_select.sv ----
// Self-checking bench of the dual source command select block.
// Assumes the design package, the top module and the contact model.
`timescale 1ns/1ps
module test_dual_source_command_select;
   import dcs_pkg::*;
   logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]         haddr, hwdata, hrdata;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [NUM_TERM-1:0] want, term_in;
   logic                fwd_terminal, rev_terminal, key_run, key_stop;
   logic                serial_run, serial_reverse;
   logic                alt_source_active, run_cmd, reverse_cmd;
   logic [1:0]          cmd_source;
   logic [3:0]          freq_source;
   logic [NUM_FRQ-1:0]  freq_source_en;
   logic [7:0]          lv_trip_level, lv_exp;
   logic                rd_ph, smp;
   logic [31:0]         expq[$];
   int unsigned         rv;
   int                  miscompares, total_checks;

   // One slave only, so its ready is the bus ready
   assign hready = hreadyout;

   dcs_top #(.DB_CYCLES(4)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .term_in(term_in),
      .fwd_terminal(fwd_terminal), .rev_terminal(rev_terminal), .key_run(key_run),
      .key_stop(key_stop), .serial_run(serial_run), .serial_reverse(serial_reverse),
      .alt_source_active(alt_source_active), .run_cmd(run_cmd),
      .reverse_cmd(reverse_cmd), .cmd_source(cmd_source), .freq_source(freq_source),
      .freq_source_en(freq_source_en), .lv_trip_level(lv_trip_level));

   dcs_contact_model i_contacts (.hclk(hclk), .want(want), .term_in(term_in));

   // 250 MHz control clock
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      repeat (2) @(posedge hclk);
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watcher: a read data phase or an output sample takes the oldest note
   always @(posedge hclk)
   begin
      if ((rd_ph === 1'b1 && hreadyout === 1'b1) || smp === 1'b1)
      begin
         if (expq.size() == 0)
            check(32'h0, 32'h1);
         else
            check(rd_ph ? hrdata : {4'h0, lv_trip_level, freq_source_en, freq_source,
                  cmd_source, reverse_cmd, run_cmd, alt_source_active}, expq.pop_front());
      end
   end

   // Waits for a rising edge at which ready is high, within a bound
   task automatic edge_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         miscompares++;
         end_sim();
      end
   endtask

   // One single word transfer; a read notes its expected data
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      edge_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      if (!wr)
      begin
         expq.push_back(e);
         rd_ph <= 1'b1;
      end
      edge_rdy();
      rd_ph <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0, e);
   endtask

   // Notes the expected selection outputs and asks the watcher for a sample
   task automatic chk_out(input logic a, input logic r, input logic v,
                          input logic [1:0] c, input logic [3:0] f);
      expq.push_back({4'h0, lv_exp, 11'h001 << f, f, c, v, r, a});
      @(posedge hclk);
      smp <= 1'b1;
      @(posedge hclk);
      smp <= 1'b0;
   endtask

   // Filtered select takes a few tens of cycles at most with a short filter
   task automatic wait_alt(input logic v);
      int n;
      n = 0;
      while (alt_source_active !== v && n < 60)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= 60)
      begin
         miscompares++;
         end_sim();
      end
   endtask

   function automatic logic [7:0] fa(input int i);
      return OFS_FUNC0 + OFS_STRIDE * 8'(i);
   endfunction

   initial
   begin
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; want = '0; fwd_terminal = 1'b0; rev_terminal = 1'b0;
      key_run = 1'b0; key_stop = 1'b0; serial_run = 1'b0; serial_reverse = 1'b0;
      rd_ph = 1'b0; smp = 1'b0; miscompares = 0; total_checks = 0; lv_exp = 8'hA5;
      rv = $urandom(32'h15A5F868);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, refused writes, read-only and unmapped places
      rd(OFS_CMD1, 32'h1);
      rd(OFS_FRQ1, 32'h0);
      rd(OFS_CMD2, 32'h1);
      rd(OFS_FRQ2, 32'h0);
      for (int i = 0; i < NUM_TERM; i++)
         rd(fa(i), (i == 4) ? 32'h4 : 32'h0);
      rd(OFS_VIN, 32'hDC);
      chk_out(1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
      wr(OFS_CMD1, 32'h4); wr(OFS_FRQ1, 32'hB); wr(fa(0), 32'h1C);
      wr(OFS_VIN, 32'hA9); wr(OFS_VIN, 32'hF1); wr(OFS_LVT, 32'h0); wr(8'h30, 32'hFF);
      rd(OFS_CMD1, 32'h1);
      rd(OFS_FRQ1, 32'h0);
      rd(fa(0), 32'h0);
      rd(OFS_VIN, 32'hDC);
      rd(OFS_LVT, 32'hA5);
      rd(8'h30, 32'h0);
      // Voltage range ends move the trip level
      wr(OFS_VIN, 32'hAA); lv_exp = 8'h7F;
      rd(OFS_LVT, 32'h7F);
      wr(OFS_VIN, 32'hF0); lv_exp = 8'hB4;
      rd(OFS_VIN, 32'hF0);
      rd(OFS_LVT, 32'hB4);
      // Every frequency source code
      for (int k = 0; k <= 10; k++)
      begin
         wr(OFS_FRQ1, 32'(k));
         chk_out(1'b0, 1'b0, 1'b0, 2'h1, 4'(k));
      end
      wr(OFS_FRQ1, 32'h0);
      // Terminal run modes, serial and keypad
      @(posedge hclk); fwd_terminal <= 1'b1;
      chk_out(1'b0, 1'b1, 1'b0, 2'h1, 4'h0);
      @(posedge hclk); fwd_terminal <= 1'b0; rev_terminal <= 1'b1;
      chk_out(1'b0, 1'b1, 1'b1, 2'h1, 4'h0);
      wr(OFS_CMD1, 32'h2);
      chk_out(1'b0, 1'b0, 1'b1, 2'h2, 4'h0);
      @(posedge hclk); fwd_terminal <= 1'b1; rev_terminal <= 1'b0;
      chk_out(1'b0, 1'b1, 1'b0, 2'h2, 4'h0);
      @(posedge hclk); fwd_terminal <= 1'b0; serial_run <= 1'b1; serial_reverse <= 1'b1;
      wr(OFS_CMD1, 32'h3);
      chk_out(1'b0, 1'b1, 1'b1, 2'h3, 4'h0);
      @(posedge hclk); serial_run <= 1'b0; serial_reverse <= 1'b0;
      wr(OFS_CMD1, 32'h0);
      chk_out(1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      @(posedge hclk); key_run <= 1'b1;
      @(posedge hclk); key_run <= 1'b0;
      chk_out(1'b0, 1'b1, 1'b0, 2'h0, 4'h0);
      @(posedge hclk); key_stop <= 1'b1;
      @(posedge hclk); key_stop <= 1'b0;
      chk_out(1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      // A terminal with another function code selects nothing
      wr(fa(0), 32'h15);
      @(posedge hclk); want[0] <= 1'b1;
      repeat (20) @(posedge hclk);
      chk_out(1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      // Second set is written before the select is made active
      wr(OFS_CMD2, 32'h2); wr(OFS_FRQ2, 32'h3);
      wr(fa(0), 32'h16);
      wait_alt(1'b1);
      chk_out(1'b1, 1'b0, 1'b0, 2'h2, 4'h3);
      @(posedge hclk); want[0] <= 1'b0;
      @(posedge hclk); want[0] <= 1'b1;
      repeat (20) @(posedge hclk);
      chk_out(1'b1, 1'b0, 1'b0, 2'h2, 4'h3);
      @(posedge hclk); want[0] <= 1'b0;
      wait_alt(1'b0);
      chk_out(1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      wr(fa(0), 32'h0);
      // Switching while running, then back to a stopped source
      wr(OFS_CMD1, 32'h3); wr(OFS_CMD2, 32'h1); wr(OFS_FRQ2, 32'h0); wr(fa(4), 32'h16);
      @(posedge hclk); serial_run <= 1'b1; fwd_terminal <= 1'b1;
      chk_out(1'b0, 1'b1, 1'b0, 2'h3, 4'h0);
      @(posedge hclk); want[4] <= 1'b1;
      wait_alt(1'b1);
      chk_out(1'b1, 1'b1, 1'b0, 2'h1, 4'h0);
      @(posedge hclk); serial_run <= 1'b0; want[4] <= 1'b0;
      wait_alt(1'b0);
      chk_out(1'b0, 1'b0, 1'b0, 2'h3, 4'h0);
      @(posedge hclk); serial_run <= 1'b1; fwd_terminal <= 1'b0; want[4] <= 1'b1;
      wait_alt(1'b1);
      chk_out(1'b1, 1'b0, 1'b0, 2'h1, 4'h0);
      // Random legal second-set codes read back
      repeat (4)
      begin
         rv = $urandom % 11;
         wr(OFS_FRQ2, rv);
         rd(OFS_FRQ2, rv);
         rv = $urandom % 4;
         wr(OFS_CMD2, rv);
         rd(OFS_CMD2, rv);
      end
      end_sim();
   end
endmodule
